// *** logic/rcio_pkg.sv ***
// Shared constants for the radio control I/O logic
package rcio_pkg;
	// Avalon register byte offsets
	localparam logic [5:0] RCIO_OFF_CTRL     = 6'h00;
	localparam logic [5:0] RCIO_OFF_STATUS   = 6'h04;
	localparam logic [5:0] RCIO_OFF_ENC      = 6'h08;
	localparam logic [5:0] RCIO_OFF_BAND     = 6'h0C;
	localparam logic [5:0] RCIO_OFF_SYN_DATA = 6'h10;
	localparam logic [5:0] RCIO_OFF_SYN_CMD  = 6'h14;
	localparam logic [5:0] RCIO_OFF_DISP     = 6'h18;
	localparam logic [5:0] RCIO_OFF_KEYS     = 6'h1C;
	localparam logic [5:0] RCIO_OFF_ID       = 6'h20;
	// Identification word, value arbitrary
	localparam logic [31:0] RCIO_ID_VALUE = 32'h0000_5A01;
	// Control register fields
	localparam int RCIO_CTL_MODE_LSB = 0;
	localparam int RCIO_CTL_RX_BIT   = 2;
	localparam int RCIO_CTL_TONE_BIT = 3;
	localparam int RCIO_CTL_BZ_BIT   = 4;
	localparam int RCIO_CTL_RED_BIT  = 5;
	localparam logic [31:0] RCIO_CTRL_RESET = 32'h0000_0004;
	// Operating modes
	typedef enum logic [1:0] {
		RCIO_MODE_SSB = 2'b00,
		RCIO_MODE_CW  = 2'b01,
		RCIO_MODE_AM  = 2'b10,
		RCIO_MODE_FM  = 2'b11
	} rcio_mode_t;
	// Serial shifter states
	typedef enum logic [2:0] {
		RCIO_SH_IDLE  = 3'b000,
		RCIO_SH_BLANK = 3'b001,
		RCIO_SH_LOW   = 3'b010,
		RCIO_SH_HIGH  = 3'b011,
		RCIO_SH_LATCH = 3'b100,
		RCIO_SH_SETTL = 3'b101
	} rcio_sh_t;
	// Break-in sequence states
	typedef enum logic [1:0] {
		RCIO_TX_RX   = 2'b00,
		RCIO_TX_BLNK = 2'b01,
		RCIO_TX_CTRL = 2'b10,
		RCIO_TX_KEY  = 2'b11
	} rcio_tx_t;
	// Timing (ns) and derived cycle counts at 25 MHz
	localparam int RCIO_CLK_NS       = 40;
	localparam int RCIO_BIT_HALF_NS  = 2000;
	localparam int RCIO_BLANK_NS     = 20000;
	localparam int RCIO_TX_STEP_NS   = 4000;
	localparam int RCIO_COL_NS       = 1000000;
	localparam int RCIO_SCAN_NS      = 80000;
	localparam logic [15:0] RCIO_BIT_HALF_CYC =
		16'((RCIO_BIT_HALF_NS + RCIO_CLK_NS - 1) / RCIO_CLK_NS);
	localparam logic [15:0] RCIO_BLANK_CYC =
		16'((RCIO_BLANK_NS + RCIO_CLK_NS - 1) / RCIO_CLK_NS);
	localparam logic [15:0] RCIO_TX_STEP_CYC =
		16'((RCIO_TX_STEP_NS + RCIO_CLK_NS - 1) / RCIO_CLK_NS);
	localparam int RCIO_COL_CYC_DEF  = RCIO_COL_NS / RCIO_CLK_NS;
	localparam logic [15:0] RCIO_SCAN_CYC =
		16'((RCIO_SCAN_NS + RCIO_CLK_NS - 1) / RCIO_CLK_NS);
	// Display and word sizes
	localparam logic [4:0] RCIO_SLOTS      = 5'd16;
	localparam logic [4:0] RCIO_SYN_BITS   = 5'd24;
	localparam int RCIO_SYN_W = 24;
endpackage : rcio_pkg

// *** logic/rcio_top.sv ***
// Radio control I/O logic: decode, encoders, display, synth loader, band and keys
// Overview of operation
// - Eight 8K chip selects from top bits
// - Encoder direction chooses up or down count
// - Main dial counts all four edges
// - Sub dial counts phase A edges only
// - Two independent counters, readable by processor
// - Select low main, high sub counter
// - Column timer pulse outputs one column
// - Refresh covers all twelve columns
// - Mode columns shown three times per cycle
// - Reference word sent once after power-on
// - Only changed synthesizer words are sent
// - Shift words out leftmost bit first
// - Four enables, one shared data line
// - Filter code fixed per frequency range
// - Oscillator selects per frequency range
// - One low scan line at a time
// - Low return input means closed key
// - Carrier stop during FM or AM receive
// - Subtone only in FM while transmitting
// - Supply monitor low clears display
// - Blank and mute around retuning
// - Transmit request runs break-in sequence
// - Unlock shows, blanks and mutes
// - Serial data and clock shared, enable pulses after last bit
`timescale 1ns/10ps
`default_nettype none
module rcio_top #(
	parameter int COL_CYC = rcio_pkg::RCIO_COL_CYC_DEF
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// Avalon-MM slave
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Processor address decode
	input  wire logic [15:0] cpu_addr,
	output logic [7:0]       chip_select_n,
	// Encoders
	input  wire logic        main_dial_phase_a,
	input  wire logic        main_dial_phase_b,
	input  wire logic        sub_dial_phase_a,
	input  wire logic        sub_dial_phase_b,
	input  wire logic        counter_read_select,
	// Display
	input  wire logic        column_timer_n,
	output logic [7:0]       disp_data,
	output logic [11:0]      disp_column,
	output logic             red_segment_line,
	// Synthesizers
	output logic             synth_serial_data,
	output logic             synth_serial_clock,
	output logic             synth1_enable,
	output logic             synth2_enable,
	output logic             synth3_enable,
	output logic             synth4_enable,
	// Band selection
	output logic [4:0]       filter_select,
	output logic             osc_select_low,
	output logic             osc_select_mid,
	output logic             osc_select_high,
	// Keys
	output logic [3:0]       key_scan_line_n,
	input  wire logic [3:0]  key_return_n,
	// Miscellaneous control and status
	output logic             mode_fm,
	output logic             mode_am,
	output logic             mode_cw,
	output logic             mode_ssb,
	output logic             carrier_stop,
	output logic             subtone_enable,
	output logic             rf_blank,
	output logic             audio_mute,
	output logic             buzzer_on,
	input  wire logic        unlock_input,
	input  wire logic        transmit_request_input,
	output logic             transmit_control,
	output logic             receive_blank,
	output logic             cw_key_out,
	input  wire logic        supply_monitor_input
);
	import rcio_pkg::*;

	assign chip_select_n = ~(8'h01 << cpu_addr[15:13]);

	// Bus: every access answers in its first cycle
	assign avs_waitrequest = 1'b0;
	wire wr_ctrl = avs_write && avs_address == RCIO_OFF_CTRL;
	wire wr_band = avs_write && avs_address == RCIO_OFF_BAND;
	wire wr_sdat = avs_write && avs_address == RCIO_OFF_SYN_DATA;
	wire wr_scmd = avs_write && avs_address == RCIO_OFF_SYN_CMD;
	wire wr_disp = avs_write && avs_address == RCIO_OFF_DISP;

	logic [31:0] ctrl_r;
	always_ff @(posedge mclk) begin
		if (!nrst) ctrl_r <= RCIO_CTRL_RESET;
		else if (wr_ctrl && avs_byteenable[0]) ctrl_r[7:0] <= avs_writedata[7:0];
	end
	rcio_mode_t mode;
	assign mode = rcio_mode_t'(ctrl_r[RCIO_CTL_MODE_LSB +: 2]);
	wire rx_mode = ctrl_r[RCIO_CTL_RX_BIT];
	assign mode_fm  = mode == RCIO_MODE_FM;
	assign mode_am  = mode == RCIO_MODE_AM;
	assign mode_cw  = mode == RCIO_MODE_CW;
	assign mode_ssb = mode == RCIO_MODE_SSB;
	assign carrier_stop = rx_mode && (mode_fm || mode_am);
	assign buzzer_on = ctrl_r[RCIO_CTL_BZ_BIT];
	assign red_segment_line = ~ctrl_r[RCIO_CTL_RED_BIT];

	// Encoder counters; reset takes the pin levels so release makes no false edge
	logic [1:0] main_q_r;
	logic [1:0] sub_q_r;
	logic [7:0] main_cnt_r;
	logic [7:0] sub_cnt_r;
	wire main_ea = main_q_r[1] ^ main_dial_phase_a;
	wire main_eb = main_q_r[0] ^ main_dial_phase_b;
	wire main_up = ~(main_ea ^ main_dial_phase_a ^ main_dial_phase_b);
	wire sub_ea = sub_q_r[1] ^ sub_dial_phase_a;
	wire sub_up = sub_dial_phase_a ^ sub_dial_phase_b;
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			main_q_r   <= {main_dial_phase_a, main_dial_phase_b};
			sub_q_r    <= {sub_dial_phase_a, sub_dial_phase_b};
			main_cnt_r <= 8'h00;
			sub_cnt_r  <= 8'h00;
		end else begin
			main_q_r <= {main_dial_phase_a, main_dial_phase_b};
			sub_q_r  <= {sub_dial_phase_a, sub_dial_phase_b};
			if (main_ea != main_eb)
				main_cnt_r <= main_up ? main_cnt_r + 8'h01 : main_cnt_r - 8'h01;
			if (sub_ea)
				sub_cnt_r <= sub_up ? sub_cnt_r + 8'h01 : sub_cnt_r - 8'h01;
		end
	end
	wire [7:0] enc_sel = counter_read_select ? sub_cnt_r : main_cnt_r;

	// Display: 16 slots per refresh; slots 12..15 repeat mode columns 0 and 1
	logic [7:0]  disp_mem [0:11];
	logic [4:0]  slot_r;
	logic        tmr_q_r;
	logic        disp_on_r;
	logic [31:0] col_cnt_r;
	wire tmr_fall = tmr_q_r && !column_timer_n;
	wire [3:0] slot_col = (slot_r < 5'd12) ? slot_r[3:0] : {3'b000, slot_r[0]};
	always_ff @(posedge mclk) begin
		if (wr_disp && avs_byteenable[0]) disp_mem[avs_writedata[11:8]] <= avs_writedata[7:0];
	end
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			tmr_q_r     <= 1'b1;
			slot_r      <= 5'd0;
			disp_data   <= 8'h00;
			disp_column <= 12'h000;
			disp_on_r   <= 1'b0;
			col_cnt_r   <= 32'd0;
		end else begin
			tmr_q_r <= column_timer_n;
			if (wr_disp && avs_writedata[31]) disp_on_r <= 1'b1;
			if (!supply_monitor_input) begin
				disp_on_r   <= 1'b0;
				disp_data   <= 8'h00;
				disp_column <= 12'h000;
			end else if (tmr_fall && disp_on_r) begin
				disp_data   <= unlock_input ? disp_mem[slot_col] : 8'hFF;
				disp_column <= 12'h001 << slot_col;
				slot_r <= (slot_r == RCIO_SLOTS - 5'd1) ? 5'd0 : slot_r + 5'd1;
				col_cnt_r <= col_cnt_r + 32'd1;
			end
		end
	end

	// Band table, range index 0..12
	logic [3:0] band_r;
	logic [4:0] fcode;
	always_ff @(posedge mclk) begin
		if (!nrst) band_r <= 4'd0;
		else if (wr_band && avs_byteenable[0] && avs_writedata[3:0] < 4'd13) band_r <= avs_writedata[3:0];
	end
	always_comb begin
		case (band_r)
			4'd0:    fcode = 5'b10000;
			4'd1:    fcode = 5'b10001;
			4'd2:    fcode = 5'b00010;
			4'd3:    fcode = 5'b00011;
			4'd4:    fcode = 5'b10000;
			4'd5:    fcode = 5'b00101;
			4'd6:    fcode = 5'b10110;
			4'd7:    fcode = 5'b00111;
			4'd8:    fcode = 5'b11000;
			4'd9:    fcode = 5'b01000;
			4'd10:   fcode = 5'b11001;
			4'd11:   fcode = 5'b01001;
			4'd12:   fcode = 5'b01010;
			default: fcode = 5'b10000;
		endcase
	end
	assign filter_select = fcode;
	assign osc_select_low  = band_r <= 4'd6;
	assign osc_select_mid  = band_r == 4'd7;
	assign osc_select_high = band_r >= 4'd10;

	// Synthesizer loader
	logic [RCIO_SYN_W-1:0] syn_word_r [0:3];
	logic [RCIO_SYN_W-1:0] syn_ref_r;
	logic [RCIO_SYN_W-1:0] syn_data_r;
	logic [3:0]  dirty_r;
	logic [3:0]  syn_seen_r;
	logic        ref_pend_r;
	logic [1:0]  cur_r;
	logic        cur_ref_r;
	logic [RCIO_SYN_W-1:0] sh_r;
	logic [4:0]  bit_r;
	logic [15:0] tim_r;
	rcio_sh_t    sh_st_r;
	logic [3:0]  en_r;
	wire busy = sh_st_r != RCIO_SH_IDLE;
	wire [1:0] syn_idx = avs_writedata[1:0];
	wire tim_done = tim_r == 16'd0;
	wire [1:0] pick = dirty_r[0] ? 2'd0 : dirty_r[1] ? 2'd1 : dirty_r[2] ? 2'd2 : 2'd3;
	wire syn_chg = !syn_seen_r[syn_idx] || syn_data_r != syn_word_r[syn_idx];
	always_ff @(posedge mclk) begin
		if (wr_scmd && avs_writedata[4]) syn_ref_r <= syn_data_r;
		if (wr_scmd && !avs_writedata[4]) syn_word_r[avs_writedata[1:0]] <= syn_data_r;
	end
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			syn_data_r <= 24'h00_0000;
			dirty_r    <= 4'h0;
			syn_seen_r <= 4'h0;
			ref_pend_r <= 1'b0;
			cur_r      <= 2'd0;
			cur_ref_r  <= 1'b0;
			sh_r       <= 24'h00_0000;
			bit_r      <= 5'd0;
			tim_r      <= 16'd0;
			sh_st_r    <= RCIO_SH_IDLE;
			en_r       <= 4'h0;
			synth_serial_data  <= 1'b0;
			synth_serial_clock <= 1'b0;
		end else begin
			if (wr_sdat) syn_data_r <= avs_writedata[RCIO_SYN_W-1:0];
			if (!tim_done) tim_r <= tim_r - 16'd1;
			// reference sent once; only accepted before first send
			if (wr_scmd && avs_writedata[4] && !cur_ref_r) ref_pend_r <= 1'b1;
			case (sh_st_r)
				RCIO_SH_IDLE: begin
					if (ref_pend_r || dirty_r != 4'h0) begin
						sh_st_r <= RCIO_SH_BLANK;
						tim_r   <= RCIO_BLANK_CYC;
						cur_r   <= ref_pend_r ? 2'd0 : pick;
						sh_r    <= ref_pend_r ? syn_ref_r : syn_word_r[pick];
						cur_ref_r <= cur_ref_r | ref_pend_r;
						if (ref_pend_r) ref_pend_r <= 1'b0;
						else dirty_r[pick] <= 1'b0;
						bit_r <= RCIO_SYN_BITS;
					end
				end
				RCIO_SH_BLANK: if (tim_done) begin
					sh_st_r <= RCIO_SH_LOW;
					tim_r   <= RCIO_BIT_HALF_CYC;
					synth_serial_data <= sh_r[RCIO_SYN_W-1];
				end
				RCIO_SH_LOW: if (tim_done) begin
					sh_st_r <= RCIO_SH_HIGH;
					tim_r   <= RCIO_BIT_HALF_CYC;
					synth_serial_clock <= 1'b1;
				end
				RCIO_SH_HIGH: if (tim_done) begin
					synth_serial_clock <= 1'b0;
					tim_r <= RCIO_BIT_HALF_CYC;
					sh_r  <= {sh_r[RCIO_SYN_W-2:0], 1'b0};
					synth_serial_data <= sh_r[RCIO_SYN_W-2];
					bit_r <= bit_r - 5'd1;
					if (bit_r == 5'd1) begin
						// latch pulse on selected enable only
						sh_st_r <= RCIO_SH_LATCH;
						en_r <= 4'h1 << cur_r;
					end else sh_st_r <= RCIO_SH_LOW;
				end
				RCIO_SH_LATCH: if (tim_done) begin
					en_r    <= 4'h0;
					sh_st_r <= RCIO_SH_SETTL;
					tim_r   <= RCIO_BLANK_CYC;
				end
				RCIO_SH_SETTL: if (tim_done) sh_st_r <= RCIO_SH_IDLE;
				default: sh_st_r <= RCIO_SH_IDLE;
			endcase
			// mark only changed words; this set beats a launch clear
			if (wr_scmd && !avs_writedata[4] && syn_chg) dirty_r[syn_idx] <= 1'b1;
			if (wr_scmd && !avs_writedata[4]) syn_seen_r[syn_idx] <= 1'b1;
		end
	end
	assign synth1_enable = en_r[0];
	assign synth2_enable = en_r[1];
	assign synth3_enable = en_r[2];
	assign synth4_enable = en_r[3];

	// Break-in sequence
	rcio_tx_t    tx_st_r;
	logic [15:0] tx_tim_r;
	wire tx_req = !transmit_request_input;
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			tx_st_r  <= RCIO_TX_RX;
			tx_tim_r <= 16'd0;
		end else begin
			if (tx_tim_r != 16'd0) tx_tim_r <= tx_tim_r - 16'd1;
			case (tx_st_r)
				RCIO_TX_RX: if (tx_req) begin
					tx_st_r <= RCIO_TX_BLNK;
					tx_tim_r <= RCIO_TX_STEP_CYC;
				end
				RCIO_TX_BLNK: if (tx_tim_r == 16'd0) begin
					tx_st_r  <= tx_req ? RCIO_TX_CTRL : RCIO_TX_RX;
					tx_tim_r <= RCIO_TX_STEP_CYC;
				end
				RCIO_TX_CTRL: if (tx_tim_r == 16'd0) begin
					tx_st_r  <= tx_req ? RCIO_TX_KEY : RCIO_TX_BLNK;
					tx_tim_r <= RCIO_TX_STEP_CYC;
				end
				RCIO_TX_KEY: if (!tx_req) begin
					tx_st_r <= RCIO_TX_CTRL;
					tx_tim_r <= RCIO_TX_STEP_CYC;
				end
				default: tx_st_r <= RCIO_TX_RX;
			endcase
		end
	end
	assign receive_blank    = tx_st_r != RCIO_TX_RX;
	assign transmit_control = tx_st_r == RCIO_TX_CTRL || tx_st_r == RCIO_TX_KEY;
	assign cw_key_out       = tx_st_r == RCIO_TX_KEY;
	assign subtone_enable = ctrl_r[RCIO_CTL_TONE_BIT] && mode_fm && transmit_control;
	assign rf_blank   = busy || !unlock_input;
	assign audio_mute = busy || !unlock_input;

	// Key scan
	logic [1:0]  scan_r;
	logic [15:0] scan_tim_r;
	logic [15:0] keys_r;
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			scan_r <= 2'd0;
			scan_tim_r <= RCIO_SCAN_CYC;
			keys_r <= 16'h0000;
		end else if (scan_tim_r == 16'd0) begin
			keys_r[scan_r*4 +: 4] <= ~key_return_n;
			scan_r <= scan_r + 2'd1;
			scan_tim_r <= RCIO_SCAN_CYC;
		end else scan_tim_r <= scan_tim_r - 16'd1;
	end
	assign key_scan_line_n = ~(4'h1 << scan_r);

	// Read mux, unmapped addresses read zero
	always_comb begin
		case (avs_address)
			RCIO_OFF_CTRL:     avs_readdata = ctrl_r;
			RCIO_OFF_STATUS:   avs_readdata = {27'd0, busy, ref_pend_r, !supply_monitor_input,
					!transmit_request_input, !unlock_input};
			RCIO_OFF_ENC:      avs_readdata = {16'd0, sub_cnt_r, main_cnt_r};
			RCIO_OFF_BAND:     avs_readdata = {28'd0, band_r};
			RCIO_OFF_SYN_DATA: avs_readdata = {8'd0, syn_data_r};
			RCIO_OFF_SYN_CMD:  avs_readdata = {24'd0, enc_sel};
			RCIO_OFF_DISP:     avs_readdata = {col_cnt_r[22:0], disp_on_r, 3'd0, slot_r};
			RCIO_OFF_KEYS:     avs_readdata = {16'd0, keys_r};
			RCIO_OFF_ID:       avs_readdata = RCIO_ID_VALUE;
			default:           avs_readdata = 32'h0000_0000;
		endcase
	end
endmodule : rcio_top
`default_nettype wire

// *** testbench/rcio_chk.sv ***
// Concurrent checks on the radio control I/O top ports
`timescale 1ns/10ps
`default_nettype none
module rcio_chk (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        nrst,
	// Address decode
	input wire logic [15:0] cpu_addr,
	input wire logic [7:0]  chip_select_n,
	// Modes and control
	input wire logic        mode_fm,
	input wire logic        mode_am,
	input wire logic        mode_cw,
	input wire logic        mode_ssb,
	input wire logic        carrier_stop,
	input wire logic        subtone_enable,
	input wire logic        transmit_control,
	input wire logic        receive_blank,
	input wire logic        rf_blank,
	input wire logic        audio_mute,
	input wire logic        transmit_request_input,
	input wire logic        unlock_input,
	// Synthesizers
	input wire logic        synth1_enable,
	input wire logic        synth2_enable,
	input wire logic        synth3_enable,
	input wire logic        synth4_enable,
	input wire logic        synth_serial_clock,
	// Keys and display
	input wire logic [3:0]  key_scan_line_n,
	input wire logic [11:0] disp_column
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	a_cs_decode: assert property (chip_select_n == ~(8'h01 << cpu_addr[15:13]))
		else $error("chip select does not follow top address bits");
	a_mode_onehot: assert property ($onehot({mode_fm, mode_am, mode_cw, mode_ssb}))
		else $error("mode outputs not one-hot");
	a_carrier_mode: assert property (carrier_stop |-> (mode_fm || mode_am))
		else $error("carrier stop outside FM or AM");
	a_subtone_tx: assert property (subtone_enable |-> (mode_fm && transmit_control))
		else $error("subtone outside FM transmit");
	a_scan_onehot: assert property ($onehot(~key_scan_line_n))
		else $error("scan lines not one low");
	a_synth_excl: assert property ($onehot0({synth4_enable, synth3_enable, synth2_enable, synth1_enable}))
		else $error("more than one synthesizer enable");
	a_load_blank: assert property ((synth_serial_clock || synth1_enable || synth2_enable
		|| synth3_enable || synth4_enable) |-> (rf_blank && audio_mute))
		else $error("synthesizer load without blank and mute");
	a_tx_order: assert property ($fell(transmit_request_input) |-> ##[1:3] receive_blank)
		else $error("receive blank late after transmit request");
	a_unlock_mute: assert property (!unlock_input |-> ##[0:3] (rf_blank && audio_mute))
		else $error("unlock without blank and mute");
	a_col_onehot: assert property ($onehot0(disp_column))
		else $error("more than one display column");

	cover property ($rose(synth1_enable));
	cover property ($fell(transmit_request_input));
	cover property (|disp_column[1:0]);
endmodule : rcio_chk
`default_nettype wire

// *** testbench/rcio_far.sv ***
// Far-side model: synthesizer serial receivers and key matrix
`timescale 1ns/10ps
`default_nettype none
module rcio_far (
	// Clock
	input  wire logic        mclk,
	// Synthesizer serial lines
	input  wire logic        sdat,
	input  wire logic        sclk,
	input  wire logic [3:0]  en,
	output logic [23:0]      word,
	output logic [3:0]       en_seen,
	output int               nlat,
	// Key matrix
	input  wire logic [3:0]  scan_n,
	input  wire logic [15:0] press,
	output logic [3:0]       ret_n
);
	logic [23:0] sh_r = '0;
	logic [3:0]  en_r = '0;
	initial begin
		word = '0;
		en_seen = '0;
		nlat = 0;
	end
	// bits enter at the bottom, so MSB-first words read back whole
	always @(posedge sclk) sh_r <= {sh_r[22:0], sdat};
	always @(posedge mclk) begin
		en_r <= en;
		if (|(en & ~en_r)) begin
			word <= sh_r;
			en_seen <= en;
			nlat <= nlat + 1;
		end
	end
	always_comb begin
		ret_n = 4'hF;
		for (int l = 0; l < 4; l++)
			if (!scan_n[l]) ret_n = ret_n & ~press[l*4 +: 4];
	end
endmodule : rcio_far
`default_nettype wire

// *** testbench/rcio_tb_top.sv ***
// Self-checking bench for the radio control I/O logic
`timescale 1ns/10ps
`default_nettype none
module rcio_tb_top;
	import rcio_pkg::*;
	logic mclk = 1'b0, nrst = 1'b0;
	logic [5:0] avs_address = '0;
	logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
	logic [31:0] avs_writedata = '0, avs_readdata, rd;
	logic [3:0] avs_byteenable = 4'hF;
	logic [15:0] cpu_addr = '0, key_press = '0;
	logic [7:0] chip_select_n, disp_data;
	logic main_dial_phase_a = 1'b0, main_dial_phase_b = 1'b0;
	logic sub_dial_phase_a = 1'b0, sub_dial_phase_b = 1'b0;
	logic counter_read_select = 1'b0, column_timer_n = 1'b1;
	logic [11:0] disp_column;
	logic red_segment_line, synth_serial_data, synth_serial_clock;
	logic synth1_enable, synth2_enable, synth3_enable, synth4_enable;
	logic [4:0] filter_select;
	logic osc_select_low, osc_select_mid, osc_select_high;
	logic [3:0] key_scan_line_n, key_return_n, far_en;
	logic mode_fm, mode_am, mode_cw, mode_ssb, carrier_stop, subtone_enable;
	logic rf_blank, audio_mute, buzzer_on, transmit_control, receive_blank, cw_key_out;
	logic unlock_input = 1'b1, transmit_request_input = 1'b1, supply_monitor_input = 1'b1;
	logic [23:0] far_word;
	int far_latches, n_mismatch = 0, num_checks = 0, cyc = 0;

	always #20 mclk = ~mclk;
	rcio_top i_dut (.*);
	rcio_far i_far (.mclk(mclk), .sdat(synth_serial_data), .sclk(synth_serial_clock),
		.en({synth4_enable, synth3_enable, synth2_enable, synth1_enable}),
		.word(far_word), .en_seen(far_en), .nlat(far_latches),
		.scan_n(key_scan_line_n), .press(key_press), .ret_n(key_return_n));

	task automatic conclude();
		if (n_mismatch == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic t_regs();
		bus(1'b0, RCIO_OFF_CTRL, '0);
		chk("ctrl_reset", rd, RCIO_CTRL_RESET);
		bus(1'b0, RCIO_OFF_ID, '0);
		chk("id", rd, RCIO_ID_VALUE);
		bus(1'b0, 6'h3C, '0);
		chk("unmapped", rd, 32'h0000_0000);
	endtask : t_regs
	task automatic t_decode();
		for (int w = 0; w < 8; w++) begin
			@(posedge mclk);
			cpu_addr <= 16'(w * 8192 + (w % 2) * 8191);
			@(posedge mclk);
			chk("chip_select_n", 32'(chip_select_n), {24'h00_0000, ~(8'h01 << w)});
		end
	endtask : t_decode
	task automatic t_band();
		// Each row: filter code, then oscillator select high, mid, low
		logic [7:0] tbl [13] = '{8'h81, 8'h89, 8'h11, 8'h19, 8'h81, 8'h29, 8'hB1,
			8'h3A, 8'hC0, 8'h40, 8'hCC, 8'h4C, 8'h54};
		for (int i = 0; i < 13; i++) begin
			bus(1'b1, RCIO_OFF_BAND, 32'(i));
			tick(2);
			chk("band", 32'({filter_select, osc_select_high, osc_select_mid, osc_select_low}),
				32'(tbl[i]));
		end
		bus(1'b1, RCIO_OFF_BAND, 32'h0000_000D);
		tick(2);
		chk("band_refused", 32'(filter_select), 32'h0000_000A);
	endtask : t_band
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, RCIO_OFF_CTRL, 32'(m) | 32'h0000_0004);
			tick(2);
			chk("modes", 32'({mode_fm, mode_am, mode_cw, mode_ssb}), 32'h0000_0001 << m);
			chk("carrier_stop", 32'(carrier_stop), 32'(m >= 2));
		end
		bus(1'b1, RCIO_OFF_CTRL, 32'h0000_0034);
		tick(2);
		chk("bz_red", 32'({mode_ssb, buzzer_on, red_segment_line}), 32'h0000_0006);
	endtask : t_modes
	task automatic t_tx();
		bus(1'b1, RCIO_OFF_CTRL, 32'h0000_000F);
		tick(2);
		chk("subtone_rx", 32'(subtone_enable), 32'h0000_0000);
		transmit_request_input <= 1'b0;
		tick(20);
		chk("tx_step1", 32'({receive_blank, transmit_control, cw_key_out}), 32'h0000_0004);
		bus(1'b1, RCIO_OFF_CTRL, 32'h0000_000B);
		tick(130);
		chk("tx_step2", 32'({receive_blank, transmit_control, cw_key_out}), 32'h0000_0006);
		tick(100);
		chk("tx_step3", 32'({receive_blank, transmit_control, cw_key_out}), 32'h0000_0007);
		chk("subtone_tx", 32'(subtone_enable), 32'h0000_0001);
		bus(1'b1, RCIO_OFF_CTRL, 32'h0000_000F);
		transmit_request_input <= 1'b1;
		tick(20);
		chk("rx_step1", 32'({receive_blank, transmit_control, cw_key_out}), 32'h0000_0006);
		tick(130);
		chk("rx_step2", 32'({receive_blank, transmit_control, cw_key_out}), 32'h0000_0004);
		tick(100);
		chk("rx_step3", 32'({receive_blank, transmit_control, cw_key_out}), 32'h0000_0000);
	endtask : t_tx
	task automatic quad(input logic main, input logic [1:0] ab);
		@(posedge mclk);
		if (main)
			{main_dial_phase_a, main_dial_phase_b} <= ab;
		else
			{sub_dial_phase_a, sub_dial_phase_b} <= ab;
		tick(4);
	endtask : quad
	task automatic t_enc();
		// One full encoder cycle with phase A leading
		logic [1:0] fwd [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
		for (int i = 0; i < 4; i++) quad(1'b1, fwd[i]);
		for (int i = 0; i < 4; i++) quad(1'b0, fwd[i]);
		bus(1'b0, RCIO_OFF_SYN_CMD, '0);
		chk("main_count", rd & 32'h0000_00FF, 32'h0000_0004);
		counter_read_select <= 1'b1;
		bus(1'b0, RCIO_OFF_SYN_CMD, '0);
		chk("sub_count", rd & 32'h0000_00FF, 32'h0000_0002);
		for (int i = 0; i < 4; i++) quad(1'b1, fwd[(6 - i) % 4]);
		counter_read_select <= 1'b0;
		bus(1'b0, RCIO_OFF_SYN_CMD, '0);
		chk("main_back", rd & 32'h0000_00FF, 32'h0000_0000);
	endtask : t_enc
	task automatic wait_idle();
		tick(4);
		for (int i = 0; i < 5000; i++) begin
			bus(1'b0, RCIO_OFF_STATUS, '0);
			if (rd[4] === 1'b0) break;
		end
		tick(4);
	endtask : wait_idle
	task automatic t_synth();
		int n;
		bus(1'b1, RCIO_OFF_SYN_DATA, 32'h00A5_C396);
		bus(1'b1, RCIO_OFF_SYN_CMD, 32'h0000_0010);
		wait_idle();
		chk("ref_word", 32'(far_word), 32'h00A5_C396);
		chk("ref_enable", 32'(far_en), 32'h0000_0001);
		bus(1'b1, RCIO_OFF_SYN_DATA, 32'h005A_3C69);
		bus(1'b1, RCIO_OFF_SYN_CMD, 32'h0000_0002);
		wait_idle();
		chk("prog_word", 32'(far_word), 32'h005A_3C69);
		chk("prog_enable", 32'(far_en), 32'h0000_0004);
		n = far_latches;
		bus(1'b1, RCIO_OFF_SYN_CMD, 32'h0000_0002);
		bus(1'b1, RCIO_OFF_SYN_CMD, 32'h0000_0010);
		wait_idle();
		chk("no_reload", 32'(far_latches), 32'(n));
	endtask : t_synth
	task automatic pulse();
		column_timer_n <= 1'b0;
		tick(3);
		column_timer_n <= 1'b1;
		tick(6);
	endtask : pulse
	task automatic t_disp();
		int cnt [12] = '{default: 0};
		bus(1'b1, RCIO_OFF_DISP, 32'h8000_055A);
		for (int p = 0; p < 16; p++) begin
			pulse();
			for (int c = 0; c < 12; c++) cnt[c] += int'(disp_column[c]);
			if (disp_column[5] === 1'b1) chk("column_data", 32'(disp_data), 32'h0000_005A);
		end
		for (int c = 0; c < 12; c++) chk("column_count", 32'(cnt[c]), (c < 2) ? 3 : 1);
		unlock_input <= 1'b0;
		pulse();
		chk("unlock_blank", 32'({rf_blank, audio_mute}), 32'h0000_0003);
		chk("unlock_disp", 32'(disp_data), 32'h0000_00FF);
		unlock_input <= 1'b1;
		supply_monitor_input <= 1'b0;
		pulse();
		chk("supply_clear", 32'(disp_data), 32'h0000_0000);
		supply_monitor_input <= 1'b1;
	endtask : t_disp
	task automatic t_keys();
		key_press <= 16'h0200;
		tick(17000);
		bus(1'b0, RCIO_OFF_KEYS, '0);
		chk("keys", rd & 32'h0000_FFFF, 32'h0000_0200);
		key_press <= '0;
	endtask : t_keys

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			conclude();
		end
	end
	initial begin
		tick(2);
		nrst <= 1'b1;
		t_regs();
		t_decode();
		t_band();
		t_modes();
		t_tx();
		t_enc();
		t_synth();
		t_disp();
		t_keys();
		conclude();
	end
endmodule : rcio_tb_top
bind rcio_top rcio_chk i_chk (.*);
`default_nettype wire
